// File: design/lcdcd_top.sv
// Purpose: Command decoder and display RAM port of a dot-matrix display controller
// Assumes: Host pins are asynchronous; parallel or write-only serial link
// Notes:   Decoded settings appear as registered output levels

`timescale 1ns/1ns
`default_nettype none

module lcdcd_top (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       PARALLEL_SELECT,
   input  wire logic       CS_N,
   input  wire logic       REGISTER_SELECT,
   input  wire logic       WR_N,
   input  wire logic       RD_N,
   input  wire logic [7:0] DATA_IN,
   input  wire logic       SCLK,
   input  wire logic       SID,
   output logic      [7:0] DATA_OUT,
   output logic            DATA_OE,
   output logic            PANEL_ON,
   output logic      [5:0] START_LINE,
   output logic      [3:0] PAGE_ADDR,
   output logic      [7:0] COLUMN_ADDR,
   output logic            SEGMENT_REVERSE,
   output logic            INVERT_PIXELS,
   output logic            ALL_PIXELS_ON,
   output logic            COMMON_REVERSE,
   output logic            BOOSTER_ENABLE,
   output logic            REGULATOR_ENABLE,
   output logic            FOLLOWER_ENABLE,
   output logic      [2:0] RESISTOR_RATIO,
   output logic      [5:0] REF_VOLT,
   output logic            INDICATOR_MODE,
   output logic      [1:0] INDICATOR_VALUE,
   output logic            BIAS_SELECT,
   output logic            POWER_SAVE,
   output logic            MODIFY_READ,
   output logic            BUSY
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [lcdcd_pkg::PIN_W-1:0] s1;
      logic [lcdcd_pkg::PIN_W-1:0] s2;
      logic [lcdcd_pkg::PIN_W-1:0] s3;
      logic [lcdcd_pkg::PIN_W-1:0] flt;
      lcdcd_pkg::lcdcd_mode_t      mode;
      logic [2:0]                  bit_cnt;
      logic [7:0]                  shreg;
      logic [6:0]                  rst_cnt;
      logic                        busy;
      logic                        panel_on;
      logic [5:0]                  start_line;
      logic [3:0]                  page;
      logic [7:0]                  col;
      logic [7:0]                  col_save;
      logic                        rmw;
      logic                        seg_rev;
      logic                        invert;
      logic                        all_on;
      logic                        com_rev;
      logic                        booster;
      logic                        regulator;
      logic                        follower;
      logic [2:0]                  ratio;
      logic [5:0]                  ref_volt;
      logic                        ind_mode;
      logic [1:0]                  ind_value;
      logic                        bias;
      logic                        power_save;
      logic [7:0]                  data_out;
      logic                        data_oe;
      logic                        rd_is_data;
   } lcdcd_regs_t;

   lcdcd_regs_t q;
   lcdcd_regs_t d;

   logic [7:0]  ram [0:lcdcd_pkg::RAM_DEPTH-1];
   logic [7:0]  ram_rd_q;
   logic        ram_we;
   logic [11:0] ram_addr;
   logic [7:0]  ram_wdata;

   logic [lcdcd_pkg::PIN_W-1:0] pins;
   logic       par;
   logic       cs_act;
   logic       wr_rise;
   logic       rd_fall;
   logic       rd_rise;
   logic       sclk_rise;
   logic       byte_ev;
   logic       byte_rs;
   logic [7:0] byte_val;

   assign pins = {PARALLEL_SELECT, CS_N, REGISTER_SELECT, WR_N, RD_N, SCLK, SID, DATA_IN};

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;
      ram_we    = 1'b0;
      ram_addr  = {q.page, q.col};
      ram_wdata = 8'h00;
      byte_ev   = 1'b0;
      byte_rs   = 1'b0;
      byte_val  = 8'h00;

      // Pin sampling: a change is taken once stages two and three agree
      d.s1  = pins;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));

      par       = d.flt[lcdcd_pkg::PIN_PARALLEL];
      cs_act    = ~d.flt[lcdcd_pkg::PIN_CS_N];
      wr_rise   = ~q.flt[lcdcd_pkg::PIN_WR_N] & d.flt[lcdcd_pkg::PIN_WR_N];
      rd_fall   = q.flt[lcdcd_pkg::PIN_RD_N] & ~d.flt[lcdcd_pkg::PIN_RD_N];
      rd_rise   = ~q.flt[lcdcd_pkg::PIN_RD_N] & d.flt[lcdcd_pkg::PIN_RD_N];
      sclk_rise = ~q.flt[lcdcd_pkg::PIN_SCLK] & d.flt[lcdcd_pkg::PIN_SCLK];

      // Parallel write: byte taken at the end of the write strobe
      if (par && cs_act && wr_rise) begin
         byte_ev  = 1'b1;
         byte_rs  = q.flt[lcdcd_pkg::PIN_RSEL];
         byte_val = q.flt[7:0];
      end

      // Serial write, MSB first, eight clocks to a byte
      if (par || !cs_act) begin
         d.bit_cnt = 3'h0;
      end else if (sclk_rise) begin
         d.shreg   = {q.shreg[6:0], d.flt[lcdcd_pkg::PIN_SID]};
         d.bit_cnt = q.bit_cnt + 3'h1;
         if (q.bit_cnt == 3'h7) begin
            byte_ev  = 1'b1;
            byte_rs  = d.flt[lcdcd_pkg::PIN_RSEL];
            byte_val = {q.shreg[6:0], d.flt[lcdcd_pkg::PIN_SID]};
         end
      end

      if (q.rst_cnt != 7'h00) begin
         d.rst_cnt = q.rst_cnt - 7'h01;
      end

      // Reads exist only on the parallel link
      if (par && cs_act && rd_fall) begin
         // Select may change together with the strobe, so take it from the same sample
         d.data_oe    = 1'b1;
         d.rd_is_data = d.flt[lcdcd_pkg::PIN_RSEL];
         if (d.flt[lcdcd_pkg::PIN_RSEL]) begin
            d.data_out = ram_rd_q;
         end else begin
            d.data_out = {q.busy, q.seg_rev, q.panel_on, q.busy, 4'h0};
         end
      end
      if (q.data_oe && (rd_rise || !cs_act || !par)) begin
         d.data_oe = 1'b0;
         if (rd_rise && q.rd_is_data && !q.rmw) begin
            d.col = q.col + 8'h01;
         end
      end

      // Bytes arriving while the reset sequence runs are dropped
      if (byte_ev && q.rst_cnt == 7'h00) begin
         if (byte_rs) begin
            ram_we    = 1'b1;
            ram_wdata = byte_val;
            d.col     = q.col + 8'h01;
         end else begin
            unique case (q.mode)
               lcdcd_pkg::LCDCD_WAIT_REF: begin
                  d.ref_volt = byte_val[5:0];
                  d.mode     = lcdcd_pkg::LCDCD_IDLE;
               end
               lcdcd_pkg::LCDCD_WAIT_IND: begin
                  d.ind_value = byte_val[1:0];
                  d.mode      = lcdcd_pkg::LCDCD_IDLE;
               end
               lcdcd_pkg::LCDCD_IDLE: begin
                  if ((byte_val & lcdcd_pkg::MK_PANEL) == lcdcd_pkg::OP_PANEL) begin
                     d.panel_on = byte_val[0];
                  end else if ((byte_val & lcdcd_pkg::MK_START) == lcdcd_pkg::OP_START) begin
                     d.start_line = byte_val[5:0];
                  end else if ((byte_val & lcdcd_pkg::MK_PAGE) == lcdcd_pkg::OP_PAGE) begin
                     d.page = byte_val[3:0];
                  end else if ((byte_val & lcdcd_pkg::MK_COL_HI) == lcdcd_pkg::OP_COL_HI) begin
                     d.col = {byte_val[3:0], q.col[3:0]};
                  end else if ((byte_val & lcdcd_pkg::MK_COL_LO) == lcdcd_pkg::OP_COL_LO) begin
                     d.col = {q.col[7:4], byte_val[3:0]};
                  end else if ((byte_val & lcdcd_pkg::MK_SEG_DIR) == lcdcd_pkg::OP_SEG_DIR) begin
                     d.seg_rev = byte_val[0];
                  end else if ((byte_val & lcdcd_pkg::MK_INVERT) == lcdcd_pkg::OP_INVERT) begin
                     d.invert = byte_val[0];
                  end else if ((byte_val & lcdcd_pkg::MK_ALL_ON) == lcdcd_pkg::OP_ALL_ON) begin
                     d.all_on = byte_val[0];
                  end else if ((byte_val & lcdcd_pkg::MK_BIAS) == lcdcd_pkg::OP_BIAS) begin
                     d.bias = byte_val[0];
                  end else if ((byte_val & lcdcd_pkg::MK_COM_DIR) == lcdcd_pkg::OP_COM_DIR) begin
                     d.com_rev = byte_val[lcdcd_pkg::BIT_COM_DIR];
                  end else if ((byte_val & lcdcd_pkg::MK_POWER) == lcdcd_pkg::OP_POWER) begin
                     d.booster   = byte_val[lcdcd_pkg::BIT_BOOSTER];
                     d.regulator = byte_val[lcdcd_pkg::BIT_REGUL];
                     d.follower  = byte_val[lcdcd_pkg::BIT_FOLLOW];
                  end else if ((byte_val & lcdcd_pkg::MK_RATIO) == lcdcd_pkg::OP_RATIO) begin
                     d.ratio = byte_val[2:0];
                  end else if ((byte_val & lcdcd_pkg::MK_REF_MODE) == lcdcd_pkg::OP_REF_MODE) begin
                     d.mode = lcdcd_pkg::LCDCD_WAIT_REF;
                  end else if ((byte_val & lcdcd_pkg::MK_IND_MODE) == lcdcd_pkg::OP_IND_MODE) begin
                     d.ind_mode = byte_val[0];
                     d.mode     = lcdcd_pkg::LCDCD_WAIT_IND;
                  end else if ((byte_val & lcdcd_pkg::MK_RMW_ENTER)
                               == lcdcd_pkg::OP_RMW_ENTER) begin
                     d.rmw      = 1'b1;
                     d.col_save = q.col;
                  end else if ((byte_val & lcdcd_pkg::MK_RMW_EXIT) == lcdcd_pkg::OP_RMW_EXIT) begin
                     d.rmw = 1'b0;
                     if (q.rmw) begin
                        d.col = q.col_save;
                     end
                  end else if ((byte_val & lcdcd_pkg::MK_SOFT_RST) == lcdcd_pkg::OP_SOFT_RST) begin
                     d.rst_cnt    = lcdcd_pkg::RESET_CYCLES;
                     d.panel_on   = 1'b0;
                     d.start_line = lcdcd_pkg::RST_START_LINE;
                     d.page       = lcdcd_pkg::RST_PAGE;
                     d.col        = lcdcd_pkg::RST_COLUMN;
                     d.col_save   = lcdcd_pkg::RST_COLUMN;
                     d.rmw        = 1'b0;
                     d.seg_rev    = 1'b0;
                     d.invert     = 1'b0;
                     d.all_on     = 1'b0;
                     d.com_rev    = 1'b0;
                     d.booster    = 1'b0;
                     d.regulator  = 1'b0;
                     d.follower   = 1'b0;
                     d.ratio      = lcdcd_pkg::RST_RATIO;
                     d.ref_volt   = lcdcd_pkg::RST_REF_VOLT;
                     d.ind_mode   = 1'b0;
                     d.ind_value  = lcdcd_pkg::RST_IND_VALUE;
                     d.bias       = 1'b0;
                  end
                  // No-op and factory test codes fall through unchanged
               end
            endcase
         end
      end

      d.busy       = (d.rst_cnt != 7'h00);
      d.power_save = ~d.panel_on & d.all_on;
   end

   // ************************************************************
   // Registers and display RAM
   // ************************************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '{s1: '1, s2: '1, s3: '1, flt: '1,
                mode: lcdcd_pkg::LCDCD_IDLE,
                bit_cnt: 3'h0, shreg: lcdcd_pkg::RST_BYTE, rst_cnt: 7'h00,
                start_line: lcdcd_pkg::RST_START_LINE, page: lcdcd_pkg::RST_PAGE,
                col: lcdcd_pkg::RST_COLUMN, col_save: lcdcd_pkg::RST_COLUMN,
                ratio: lcdcd_pkg::RST_RATIO, ref_volt: lcdcd_pkg::RST_REF_VOLT,
                ind_value: lcdcd_pkg::RST_IND_VALUE, data_out: lcdcd_pkg::RST_BYTE,
                default: 1'b0};
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge CLK) begin
      if (ram_we) begin
         ram[ram_addr] <= ram_wdata;
      end
      ram_rd_q <= ram[{q.page, q.col}];
   end

   assign DATA_OUT         = q.data_out;
   assign DATA_OE          = q.data_oe;
   assign PANEL_ON         = q.panel_on;
   assign START_LINE       = q.start_line;
   assign PAGE_ADDR        = q.page;
   assign COLUMN_ADDR      = q.col;
   assign SEGMENT_REVERSE  = q.seg_rev;
   assign INVERT_PIXELS    = q.invert;
   assign ALL_PIXELS_ON    = q.all_on;
   assign COMMON_REVERSE   = q.com_rev;
   assign BOOSTER_ENABLE   = q.booster;
   assign REGULATOR_ENABLE = q.regulator;
   assign FOLLOWER_ENABLE  = q.follower;
   assign RESISTOR_RATIO   = q.ratio;
   assign REF_VOLT         = q.ref_volt;
   assign INDICATOR_MODE   = q.ind_mode;
   assign INDICATOR_VALUE  = q.ind_value;
   assign BIAS_SELECT      = q.bias;
   assign POWER_SAVE       = q.power_save;
   assign MODIFY_READ      = q.rmw;
   assign BUSY             = q.busy;

endmodule

`default_nettype wire

// File: design/lcdcd_pkg.sv
// Purpose: Constants and types of the display controller command decoder
// Assumes: 100 MHz clock, host pins sampled through three flip-flops
// Notes:   Opcode values go with a mask; a byte matches when (byte & mask) == value
//
// Contract
// - Command 1010111x turns the panel off on bit 0 low, on when high.
// - Command 01xxxxxx loads six low bits as the RAM line shown on row 0.
// - 1011pppp loads page; 0001hhhh column high nibble; 0000llll column low nibble.
// - Status read: busy, segment direction, panel on, resetting, then four zeros.
// - Data write stores the byte into RAM at current page and column.
// - Data read returns the RAM byte at current page and column.
// - Command 1010000x selects normal or reversed segment order.
// - Command 1010011x selects normal or inverted pixel polarity.
// - Command 1010010x selects RAM display or every pixel forced on.
// - Command 11100010 returns internal functions to their initial state.
// - Command 1100sxxx selects normal or reversed common scan from bit 3.
// - Command 00101abc stores booster, regulator and follower enables.
// - Command 00100rrr stores the 3-bit regulator resistance ratio.
// - Command 10000001 arms; next byte's six low bits become reference voltage.
// - Command 1010110m sets indicator mode; next byte's two low bits set value.
// - Power save is display off together with all pixels on.
// - Serial link is write only; strobes stay fixed, RAM cannot be read.

package lcdcd_pkg;

   // Positions of host pins inside the sampled pin vector
   localparam int PIN_W        = 15;
   localparam int PIN_PARALLEL = 14;
   localparam int PIN_CS_N     = 13;
   localparam int PIN_RSEL     = 12;
   localparam int PIN_WR_N     = 11;
   localparam int PIN_RD_N     = 10;
   localparam int PIN_SCLK     = 9;
   localparam int PIN_SID      = 8;

   // Opcode values and masks
   localparam logic [7:0] OP_PANEL     = 8'hAE, MK_PANEL     = 8'hFE;
   localparam logic [7:0] OP_START     = 8'h40, MK_START     = 8'hC0;
   localparam logic [7:0] OP_PAGE      = 8'hB0, MK_PAGE      = 8'hF0;
   localparam logic [7:0] OP_COL_HI    = 8'h10, MK_COL_HI    = 8'hF0;
   localparam logic [7:0] OP_COL_LO    = 8'h00, MK_COL_LO    = 8'hF0;
   localparam logic [7:0] OP_SEG_DIR   = 8'hA0, MK_SEG_DIR   = 8'hFE;
   localparam logic [7:0] OP_INVERT    = 8'hA6, MK_INVERT    = 8'hFE;
   localparam logic [7:0] OP_ALL_ON    = 8'hA4, MK_ALL_ON    = 8'hFE;
   localparam logic [7:0] OP_BIAS      = 8'hA2, MK_BIAS      = 8'hFE;
   localparam logic [7:0] OP_COM_DIR   = 8'hC0, MK_COM_DIR   = 8'hF0;
   localparam logic [7:0] OP_POWER     = 8'h28, MK_POWER     = 8'hF8;
   localparam logic [7:0] OP_RATIO     = 8'h20, MK_RATIO     = 8'hF8;
   localparam logic [7:0] OP_REF_MODE  = 8'h81, MK_REF_MODE  = 8'hFF;
   localparam logic [7:0] OP_IND_MODE  = 8'hAC, MK_IND_MODE  = 8'hFE;
   localparam logic [7:0] OP_RMW_ENTER = 8'hE0, MK_RMW_ENTER = 8'hFF;
   localparam logic [7:0] OP_RMW_EXIT  = 8'hEE, MK_RMW_EXIT  = 8'hFF;
   localparam logic [7:0] OP_SOFT_RST  = 8'hE2, MK_SOFT_RST  = 8'hFF;
   localparam logic [7:0] OP_NOP       = 8'hE3, MK_NOP       = 8'hFF;

   // Bit positions inside command bytes
   localparam int BIT_COM_DIR = 3;
   localparam int BIT_BOOSTER = 2;
   localparam int BIT_REGUL   = 1;
   localparam int BIT_FOLLOW  = 0;

   // Values after reset
   localparam logic [5:0] RST_START_LINE = 6'h00;
   localparam logic [3:0] RST_PAGE       = 4'h0;
   localparam logic [7:0] RST_COLUMN     = 8'h00;
   localparam logic [2:0] RST_RATIO      = 3'h0;
   localparam logic [5:0] RST_REF_VOLT   = 6'h00;
   localparam logic [1:0] RST_IND_VALUE  = 2'h0;
   localparam logic [7:0] RST_BYTE       = 8'h00;

   // Length of the internal reset sequence
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         RESET_TIME_NS = 1000;
   localparam logic [6:0] RESET_CYCLES  = 7'(RESET_TIME_NS / CLK_PERIOD_NS);

   localparam int RAM_DEPTH = 4096;

   typedef enum logic [1:0] {LCDCD_IDLE, LCDCD_WAIT_REF, LCDCD_WAIT_IND} lcdcd_mode_t;

endpackage

// File: tb/lcdcd_checker.sv
// Purpose: Port assertions for the command decoder top
// Assumes: Host keeps strobe phases of at least 4 cycles
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module lcdcd_checker (
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       PARALLEL_SELECT,
   input wire logic       CS_N,
   input wire logic       REGISTER_SELECT,
   input wire logic       WR_N,
   input wire logic       RD_N,
   input wire logic [7:0] DATA_OUT,
   input wire logic       DATA_OE,
   input wire logic       PANEL_ON,
   input wire logic [3:0] PAGE_ADDR,
   input wire logic [7:0] COLUMN_ADDR,
   input wire logic       SEGMENT_REVERSE,
   input wire logic       INVERT_PIXELS,
   input wire logic       ALL_PIXELS_ON,
   input wire logic       BIAS_SELECT,
   input wire logic       POWER_SAVE,
   input wire logic       BUSY
);
   logic [7:0] busy_cnt_q;
   logic [7:0] busy_cnt_d;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   always_comb busy_cnt_d = BUSY ? busy_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) busy_cnt_q <= 8'h00;
      else busy_cnt_q <= busy_cnt_d;
   end
   a_power_save_mix: assert property (POWER_SAVE == (!PANEL_ON && ALL_PIXELS_ON))
      else $error("power save differs from panel off with all pixels on");
   a_status_read_fmt: assert property ((PARALLEL_SELECT && !CS_N && !RD_N && !REGISTER_SELECT)[*8]
      |-> DATA_OE && DATA_OUT[3:0] == 4'h0 && DATA_OUT[5] == PANEL_ON)
      else $error("status byte wrong or not driven");
   a_serial_no_drive: assert property (!PARALLEL_SELECT[*8] |-> !DATA_OE)
      else $error("data bus driven in serial mode");
   a_idle_no_drive: assert property (RD_N[*8] |-> !DATA_OE)
      else $error("data bus driven without read strobe");
   a_busy_length: assert property ($fell(BUSY) |-> busy_cnt_q == 8'h64)
      else $error("internal reset length wrong");
   a_busy_bound: assert property (busy_cnt_q <= 8'h64)
      else $error("busy stays high too long");
   a_reset_clears: assert property ($rose(BUSY) |-> ##[0:1] (!PANEL_ON && !SEGMENT_REVERSE
      && !INVERT_PIXELS && PAGE_ADDR == 4'h0 && COLUMN_ADDR == 8'h00))
      else $error("software reset left settings");
   a_busy_drops: assert property (BUSY && $past(BUSY, 2) |-> $stable(INVERT_PIXELS)
      && $stable(PAGE_ADDR) && $stable(PANEL_ON))
      else $error("setting changed while busy");
   a_settings_hold: assert property ((WR_N && PARALLEL_SELECT)[*8] |-> $stable(INVERT_PIXELS)
      && $stable(ALL_PIXELS_ON) && $stable(SEGMENT_REVERSE) && $stable(BIAS_SELECT))
      else $error("setting changed without a write");
   c_soft_reset: cover property ($rose(BUSY));
   c_power_save: cover property ($rose(POWER_SAVE));
   c_data_read: cover property ($rose(DATA_OE) && REGISTER_SELECT);
endmodule
bind lcdcd_top lcdcd_checker u_lcdcd_checker (.*);
`default_nettype wire

// File: tb/lcdcd_host.sv
// Purpose: Host processor model on the parallel and serial link
// Assumes: Pins change on the falling clock edge
// Notes:   A released data bus shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module lcdcd_host (
   input  wire logic       clk,
   input  wire logic [7:0] dout,
   input  wire logic       oe,
   output logic            ps,
   output logic            cs_n,
   output logic            rs,
   output logic            wr_n,
   output logic            rd_n,
   output logic            sclk,
   output logic            sid,
   output logic      [7:0] dq
);
   initial begin
      ps = 1'b1;
      cs_n = 1'b1;
      rs = 1'b0;
      wr_n = 1'b1;
      rd_n = 1'b1;
      sclk = 1'b1;
      sid = 1'b1;
      dq = 8'hFF;
   end
   task automatic mode(input logic p);
      ps = p;
      repeat (6) @(negedge clk);
   endtask
   // Callers never pass the factory test forms 1111xxxx or 1001xxxx as commands
   // Argument bytes of two-byte commands go out as plain commands
   task automatic wr(input logic r, input logic [7:0] b);
      cs_n = 1'b0;
      rs = r;
      dq = b;
      wr_n = 1'b0;
      repeat (6) @(negedge clk);
      wr_n = 1'b1;
      repeat (5) @(negedge clk);
      cs_n = 1'b1;
      dq = ~b;
      repeat (6) @(negedge clk);
   endtask
   task automatic rd(input logic r, output logic [8:0] b);
      cs_n = 1'b0;
      rs = r;
      rd_n = 1'b0;
      repeat (8) @(negedge clk);
      b = {oe, dout};
      rd_n = 1'b1;
      repeat (6) @(negedge clk);
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Strobes stay high; clock stands still outside the frame
   task automatic ser(input logic r, input logic [7:0] b);
      cs_n = 1'b0;
      rs = r;
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         sid = b[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sid = ~b[0];
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// File: tb/lcd_command_decoder_tb.sv
// Purpose: Self-checking bench for the command decoder
// Assumes: Settings visible some 4 cycles after the write strobe rises
// Notes:   Command table first, then data, status, reset and serial cases
`timescale 1ns/1ns
`default_nettype none
module lcd_command_decoder_tb;
   typedef struct packed {logic [7:0] cmd; logic [3:0] sel; logic [7:0] exp;} lcdcd_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic ps, cs_n, rs, wr_n, rd_n, sclk, sid;
   wire logic [7:0] dq;
   logic [7:0] dout, col;
   logic [5:0] sline, vref;
   logic [3:0] page;
   logic [2:0] ratio;
   logic [1:0] ival;
   logic oe, pon, seg, inv, allon, comr, boo, rege, fol, imode, bias, psave, mrd, busy;
   logic [8:0] got;
   int mismatches = 0;
   int n_checks = 0;
   localparam lcdcd_row_t ROWS [22] = '{
      '{8'hAF, 4'h0, 8'h01}, '{8'hAE, 4'h0, 8'h00},
      '{8'h7F, 4'h1, 8'h3F}, '{8'hB9, 4'h2, 8'h09},
      '{8'h1A, 4'h3, 8'hA0}, '{8'h05, 4'h3, 8'hA5},
      '{8'hA1, 4'h4, 8'h01}, '{8'hA7, 4'h5, 8'h01},
      '{8'hA5, 4'h6, 8'h01}, '{8'hE3, 4'h7, 8'h01},
      '{8'hCF, 4'h8, 8'h01}, '{8'h2D, 4'h9, 8'h05},
      '{8'h26, 4'hA, 8'h06}, '{8'h81, 4'hB, 8'h00},
      '{8'hC5, 4'hB, 8'h05}, '{8'hAD, 4'hC, 8'h04},
      '{8'hE6, 4'hC, 8'h06}, '{8'hA3, 4'hD, 8'h01},
      '{8'hA6, 4'h5, 8'h00}, '{8'hB5, 4'h2, 8'h05},
      '{8'hE0, 4'hE, 8'h01}, '{8'hEE, 4'hE, 8'h00}};
   lcdcd_top u_lcdcd_top (.CLK(clk), .RST_N(rst_n), .PARALLEL_SELECT(ps), .CS_N(cs_n),
      .REGISTER_SELECT(rs), .WR_N(wr_n), .RD_N(rd_n), .DATA_IN(dq), .SCLK(sclk), .SID(sid),
      .DATA_OUT(dout), .DATA_OE(oe), .PANEL_ON(pon), .START_LINE(sline), .PAGE_ADDR(page),
      .COLUMN_ADDR(col), .SEGMENT_REVERSE(seg), .INVERT_PIXELS(inv), .ALL_PIXELS_ON(allon),
      .COMMON_REVERSE(comr), .BOOSTER_ENABLE(boo), .REGULATOR_ENABLE(rege),
      .FOLLOWER_ENABLE(fol), .RESISTOR_RATIO(ratio), .REF_VOLT(vref), .INDICATOR_MODE(imode),
      .INDICATOR_VALUE(ival), .BIAS_SELECT(bias), .POWER_SAVE(psave), .MODIFY_READ(mrd),
      .BUSY(busy));
   lcdcd_host u_host (.clk(clk), .dout(dout), .oe(oe), .ps(ps), .cs_n(cs_n), .rs(rs),
      .wr_n(wr_n), .rd_n(rd_n), .sclk(sclk), .sid(sid), .dq(dq));
   always #5 clk = ~clk;
   function automatic logic [7:0] pick(input logic [3:0] s);
      case (s)
         4'h0: return {7'h00, pon};
         4'h1: return {2'h0, sline};
         4'h2: return {4'h0, page};
         4'h3: return col;
         4'h4: return {7'h00, seg};
         4'h5: return {7'h00, inv};
         4'h6: return {7'h00, allon};
         4'h7: return {7'h00, psave};
         4'h8: return {7'h00, comr};
         4'h9: return {5'h00, boo, rege, fol};
         4'hA: return {5'h00, ratio};
         4'hB: return {2'h0, vref};
         4'hC: return {5'h00, imode, ival};
         4'hD: return {7'h00, bias};
         default: return {7'h00, mrd};
      endcase
   endfunction
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ************************************
   // Main sequence
   // ************************************
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 22; i++) begin
         u_host.wr(1'b0, ROWS[i].cmd);
         chk({1'b0, pick(ROWS[i].sel)}, {1'b0, ROWS[i].exp});
      end
      $display("test command table done");
      u_host.wr(1'b0, 8'hB2);
      u_host.wr(1'b0, 8'h13);
      u_host.wr(1'b0, 8'h0F);
      u_host.wr(1'b1, 8'h3C);
      u_host.wr(1'b1, 8'hC3);
      chk({1'b0, col}, 9'h041);
      u_host.wr(1'b0, 8'h13);
      u_host.wr(1'b0, 8'h0F);
      u_host.rd(1'b1, got);
      chk(got, 9'h13C);
      u_host.rd(1'b1, got);
      chk(got, 9'h1C3);
      u_host.wr(1'b0, 8'h1F);
      u_host.wr(1'b0, 8'h0F);
      u_host.wr(1'b1, 8'h5A);
      chk({1'b0, col}, 9'h000);
      u_host.wr(1'b0, 8'hE0);
      u_host.wr(1'b0, 8'h1F);
      u_host.wr(1'b0, 8'h0F);
      u_host.rd(1'b1, got);
      chk(got, 9'h15A);
      chk({1'b0, col}, 9'h0FF);
      u_host.wr(1'b0, 8'hEE);
      chk({1'b0, col}, 9'h000);
      $display("test display data done");
      u_host.rd(1'b0, got);
      chk(got, 9'h140);
      u_host.wr(1'b0, 8'hAF);
      u_host.rd(1'b0, got);
      chk(got, 9'h160);
      $display("test status done");
      u_host.wr(1'b0, 8'hE2);
      u_host.rd(1'b0, got);
      chk(got, 9'h190);
      u_host.wr(1'b0, 8'hA7);
      for (int i = 0; i < 150 && busy !== 1'b0; i++) @(negedge clk);
      chk({8'h00, busy}, 9'h000);
      if (busy !== 1'b0) report_and_stop();
      chk({pick(4'h5), seg}, 9'h000);
      $display("test software reset done");
      u_host.mode(1'b0);
      u_host.ser(1'b0, 8'hAF);
      chk({8'h00, pon}, 9'h001);
      u_host.rd(1'b0, got);
      chk({8'h00, got[8]}, 9'h000);
      u_host.mode(1'b1);
      $display("test serial done");
      rst_n = 1'b0;
      @(negedge clk);
      chk({pon, col}, 9'h000);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      $display("test pin reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
